// ===== hw/btcr_regs_map.vh
// Constants for the third buck regulator register bank
`ifndef BTCR_REGS_MAP_VH
`define BTCR_REGS_MAP_VH

// Register indexes; byte address is four times the index
`define BTCR_IDX_W 10
`define BTCR_IDX_RUN_VOLT 10'h03E
`define BTCR_IDX_STBY_VOLT 10'h03F
`define BTCR_IDX_SLP_VOLT 10'h040
`define BTCR_IDX_CTRL 10'h041

// Voltage code field
`define BTCR_CODE_W 4
`define BTCR_CODE_MSB 3
`define BTCR_CODE_LSB 0

// Control register fields
`define BTCR_CTRL_RUN_EN 0
`define BTCR_CTRL_STBY_EN 1
`define BTCR_CTRL_SLP_EN 2
`define BTCR_CTRL_LPWR 3
`define BTCR_CTRL_FCS 6
`define BTCR_CTRL_DIS_DIS 7
`define BTCR_CTRL_RST 1'b0

// Register width inside the 32-bit bus word
`define BTCR_REG_W 8
`define BTCR_DATA_ZERO 32'h00000000

// Device operating mode codes
`define BTCR_MODE_W 2
`define BTCR_MODE_RUN 2'h0
`define BTCR_MODE_STBY 2'h1
`define BTCR_MODE_SLP 2'h2
`define BTCR_MODE_OFF 2'h3

`endif

// ===== hw/btcr_sync.v
// Two-flop synchroniser bank for inputs from outside the clock domain
module btcr_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  // First stage is read only by the second stage
  reg [W-1:0] meta;
  // Second stage feeds the logic
  reg [W-1:0] stable;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // One synchroniser per bit; bits are independent levels
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta[i] <= 1'b0;
          stable[i] <= 1'b0;
        end else begin
          meta[i] <= d_i[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate

  assign q_o = stable;
endmodule

// ===== hw/btcr_regs.v
// Register bank and output control for the third buck regulator
//
// Notes on behaviour
// - Run voltage code, bits 3:0, from fuses
// - Standby voltage code, bits 3:0, from fuses
// - Sleep voltage code, bits 3:0, from fuses
// - Voltage codes are read only to software
// - Run enable resets 0, loads at sequence
// - Run enable 1 runs, 0 turns off
// - Standby enable bit 1 gates standby
// - Sleep enable bit 2, plain read-write
// - Low-power select in standby or sleep
// - Bit 6 forces continuous switching
// - Discharge bit 0 connects resistor off
// - Discharge bit 1 leaves resistor open
// - Run and standby enables and discharge load from fuses
`include "btcr_regs_map.vh"

module btcr_regs #(
  parameter ADDR_W = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire fuse_ready_i,
  input wire [3:0] fuse_run_code_i,
  input wire [3:0] fuse_stby_code_i,
  input wire [3:0] fuse_slp_code_i,
  input wire fuse_run_enable_i,
  input wire fuse_standby_enable_i,
  input wire fuse_discharge_disable_i,
  input wire seq_slot_i,
  input wire [1:0] device_mode_i,
  output reg regulator_on_o,
  output reg low_power_o,
  output reg forced_pwm_o,
  output reg discharge_connect_o,
  output reg [3:0] voltage_code_o
);
  // Sync bank width: ready, 3 codes, 3 fuse bits, slot, mode
  localparam SW = 1 + 3 * `BTCR_CODE_W + 3 + 1 + `BTCR_MODE_W;

  // Fuse load sequencing states, one-hot
  localparam S_WAIT = 3'b001;
  localparam S_LOAD = 3'b010;
  localparam S_DONE = 3'b100;

  // Synchronised copies of the pins
  wire [SW-1:0] sync_q;
  wire s_ready;
  wire [3:0] s_run_code;
  wire [3:0] s_stby_code;
  wire [3:0] s_slp_code;
  wire s_run_en;
  wire s_stby_en;
  wire s_dis_dis;
  wire s_slot;
  wire [1:0] s_mode;

  // Voltage code storage, hardware loaded only
  reg [3:0] run_voltage_code;
  reg [3:0] standby_voltage_code;
  reg [3:0] sleep_voltage_code;

  // Control register fields
  reg run_enable;
  reg standby_enable;
  reg sleep_enable;
  reg low_power_select;
  reg forced_continuous_switching;
  reg discharge_disable;

  // Load sequencing
  reg [2:0] state;
  reg [2:0] next_state;
  reg slot_d;
  reg slot_pend;

  // Bus decode
  wire [`BTCR_IDX_W-1:0] idx;
  wire hit_run;
  wire hit_stby;
  wire hit_slp;
  wire hit_ctrl;
  wire hit_any;
  wire setup;
  wire access_done;
  wire wr_ctrl;
  reg [`BTCR_REG_W-1:0] rd_byte;

  // Hardware load strobes
  wire fuse_load;
  wire run_load;
  wire slot_rise;

  // Mode qualified enable
  reg next_on;

  btcr_sync #(
    .W(SW)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({fuse_ready_i, fuse_run_code_i, fuse_stby_code_i, fuse_slp_code_i,
          fuse_run_enable_i, fuse_standby_enable_i, fuse_discharge_disable_i,
          seq_slot_i, device_mode_i}),
    .q_o(sync_q)
  );

  // Fuse data is assumed stable once ready is seen, so bits need not match up
  assign {s_ready, s_run_code, s_stby_code, s_slp_code,
          s_run_en, s_stby_en, s_dis_dis, s_slot, s_mode} = sync_q;

  // Word index of the access; low two address bits ignored
  assign idx = paddr_i[`BTCR_IDX_W+1:2];
  assign hit_run = (idx == `BTCR_IDX_RUN_VOLT);
  assign hit_stby = (idx == `BTCR_IDX_STBY_VOLT);
  assign hit_slp = (idx == `BTCR_IDX_SLP_VOLT);
  assign hit_ctrl = (idx == `BTCR_IDX_CTRL);
  assign hit_any = hit_run | hit_stby | hit_slp | hit_ctrl;

  // Setup phase and the edge where an access completes
  assign setup = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_o;

  // Only the low lane carries register data
  assign wr_ctrl = access_done & pwrite_i & hit_ctrl & pstrb_i[0];

  // Read value; unused bits forced to zero
  always @* begin
    rd_byte = {`BTCR_REG_W{1'b0}};
    if (hit_run) begin
      rd_byte[`BTCR_CODE_MSB:`BTCR_CODE_LSB] = run_voltage_code;
    end else if (hit_stby) begin
      rd_byte[`BTCR_CODE_MSB:`BTCR_CODE_LSB] = standby_voltage_code;
    end else if (hit_slp) begin
      rd_byte[`BTCR_CODE_MSB:`BTCR_CODE_LSB] = sleep_voltage_code;
    end else if (hit_ctrl) begin
      rd_byte[`BTCR_CTRL_RUN_EN] = run_enable;
      rd_byte[`BTCR_CTRL_STBY_EN] = standby_enable;
      rd_byte[`BTCR_CTRL_SLP_EN] = sleep_enable;
      rd_byte[`BTCR_CTRL_LPWR] = low_power_select;
      rd_byte[`BTCR_CTRL_FCS] = forced_continuous_switching;
      rd_byte[`BTCR_CTRL_DIS_DIS] = discharge_disable;
    end else begin
      // Unmapped word reads zero
      rd_byte = {`BTCR_REG_W{1'b0}};
    end
  end

  // APB answer: ready and data prepared in setup, so no wait states
  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `BTCR_DATA_ZERO;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= ~hit_any;
      prdata_o <= {{(32 - `BTCR_REG_W){1'b0}}, rd_byte};
    end else if (access_done) begin
      // Drop ready so a stalled setup is never answered early
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Fuse load sequencing
  always @* begin
    next_state = state;
    case (state)
      S_WAIT: begin
        if (s_ready) begin
          next_state = S_LOAD;
        end
      end
      S_LOAD: begin
        next_state = S_DONE;
      end
      S_DONE: begin
        // Stay loaded until the next reset
        next_state = S_DONE;
      end
      default: begin
        next_state = S_WAIT;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_WAIT;
    end else begin
      state <= next_state;
    end
  end

  assign fuse_load = (state == S_LOAD);
  assign slot_rise = s_slot & ~slot_d;
  // A slot seen before fuses are loaded is held until they are
  assign run_load = (state == S_DONE) & (slot_rise | slot_pend);

  // Sequencer slot edge detect and hold
  always @(posedge clk_i) begin
    if (rst_i) begin
      slot_d <= 1'b0;
      slot_pend <= 1'b0;
    end else begin
      slot_d <= s_slot;
      if (run_load) begin
        slot_pend <= 1'b0;
      end else if (slot_rise) begin
        slot_pend <= 1'b1;
      end
    end
  end

  // Voltage codes: fuses only, bus writes have no path here
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_voltage_code <= {`BTCR_CODE_W{1'b0}};
      standby_voltage_code <= {`BTCR_CODE_W{1'b0}};
      sleep_voltage_code <= {`BTCR_CODE_W{1'b0}};
    end else if (fuse_load) begin
      run_voltage_code <= s_run_code;
      standby_voltage_code <= s_stby_code;
      sleep_voltage_code <= s_slp_code;
    end
  end

  // Run enable: reset 0, fuse load at the sequence slot, then software
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_enable <= `BTCR_CTRL_RST;
    end else if (run_load) begin
      // Hardware load wins over a write in the same cycle
      run_enable <= s_run_en;
    end else if (wr_ctrl) begin
      run_enable <= pwdata_i[`BTCR_CTRL_RUN_EN];
    end
  end

  // Standby enable and discharge control: fuse load plus software
  always @(posedge clk_i) begin
    if (rst_i) begin
      standby_enable <= `BTCR_CTRL_RST;
      discharge_disable <= `BTCR_CTRL_RST;
    end else if (fuse_load) begin
      // Fuse image is expected to mirror the first buck run enable
      standby_enable <= s_stby_en;
      discharge_disable <= s_dis_dis;
    end else if (wr_ctrl) begin
      standby_enable <= pwdata_i[`BTCR_CTRL_STBY_EN];
      discharge_disable <= pwdata_i[`BTCR_CTRL_DIS_DIS];
    end
  end

  // Plain read-write fields; bits 5:4 are not stored
  always @(posedge clk_i) begin
    if (rst_i) begin
      sleep_enable <= `BTCR_CTRL_RST;
      low_power_select <= `BTCR_CTRL_RST;
      forced_continuous_switching <= `BTCR_CTRL_RST;
    end else if (wr_ctrl) begin
      sleep_enable <= pwdata_i[`BTCR_CTRL_SLP_EN];
      low_power_select <= pwdata_i[`BTCR_CTRL_LPWR];
      forced_continuous_switching <= pwdata_i[`BTCR_CTRL_FCS];
    end
  end

  // Which enable applies in the present device mode
  always @* begin
    next_on = 1'b0;
    case (s_mode)
      `BTCR_MODE_RUN: begin
        next_on = run_enable;
      end
      `BTCR_MODE_STBY: begin
        next_on = standby_enable;
      end
      `BTCR_MODE_SLP: begin
        next_on = sleep_enable;
      end
      default: begin
        // Off mode keeps the regulator down
        next_on = 1'b0;
      end
    endcase
  end

  // Power stage controls, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      regulator_on_o <= 1'b0;
      low_power_o <= 1'b0;
      forced_pwm_o <= 1'b0;
      discharge_connect_o <= 1'b0;
      voltage_code_o <= {`BTCR_CODE_W{1'b0}};
    end else begin
      regulator_on_o <= next_on;
      // Low power only applies outside run mode
      low_power_o <= next_on & low_power_select &
                     ((s_mode == `BTCR_MODE_STBY) | (s_mode == `BTCR_MODE_SLP));
      forced_pwm_o <= next_on & forced_continuous_switching;
      // Resistor only while disabled and not inhibited
      discharge_connect_o <= ~next_on & ~discharge_disable;
      // Code follows the mode; sleep and off share the sleep code
      if (s_mode == `BTCR_MODE_RUN) begin
        voltage_code_o <= run_voltage_code;
      end else if (s_mode == `BTCR_MODE_STBY) begin
        voltage_code_o <= standby_voltage_code;
      end else begin
        voltage_code_o <= sleep_voltage_code;
      end
    end
  end
endmodule

// ===== tb/btcr_regs_sva.sv
// Assertion checker for the third buck register bank
`include "btcr_regs_map.vh"
module btcr_regs_sva #(
  parameter ADDR_W = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire regulator_on_o,
  input wire low_power_o,
  input wire forced_pwm_o,
  input wire discharge_connect_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [9:0] idx = paddr_i[11:2]; // Word index of the transfer
  wire volt = (idx == `BTCR_IDX_RUN_VOLT) || (idx == `BTCR_IDX_STBY_VOLT) ||
    (idx == `BTCR_IDX_SLP_VOLT);
  wire ctrl = (idx == `BTCR_IDX_CTRL);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Setup cycle, then the completing access cycle
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_done;
    psel_i && penable_i && pready_o;
  endsequence
  // Completing read of the control word
  sequence s_rd_ctrl;
    s_done and (!pwrite_i && ctrl);
  endsequence
  // Completing read of one of the voltage words
  sequence s_rd_volt;
    s_done and (!pwrite_i && volt);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready_o)
    else $error("ready missing after setup");
  a_ready_drops: assert property (s_done |=> !pready_o)
    else $error("ready held after completion");
  a_upper_zero: assert property (s_done |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ctrl_gap_zero: assert property (s_rd_ctrl |-> prdata_o[5:4] == 2'b00)
    else $error("unused control bits not zero");
  a_volt_gap_zero: assert property (s_rd_volt |-> prdata_o[7:4] == 4'h0)
    else $error("unused voltage bits not zero");
  a_err_map: assert property (s_done |-> pslverr_o == !(volt || ctrl))
    else $error("error flag disagrees with map");
  a_lp_needs_on: assert property (low_power_o |-> regulator_on_o)
    else $error("low power while off");
  a_forced_pulse_width_mode_needs_on: assert property (forced_pwm_o |-> regulator_on_o)
    else $error("forced switching while off");
  a_dis_when_on: assert property (regulator_on_o |-> !discharge_connect_o)
    else $error("discharge connected while on");
endmodule
bind btcr_regs btcr_regs_sva #(.ADDR_W(ADDR_W)) btcr_regs_sva_i (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .regulator_on_o,
  .low_power_o, .forced_pwm_o, .discharge_connect_o);

// ===== tb/btcr_regs_bench.sv
// Self-checking bench for the third buck register bank
`include "btcr_regs_map.vh"
module btcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, psel, penable, pwrite, ready, run_en, stby_en, dis_dis, slot;
  logic pready, pslverr, on, lp, forced_pulse_width_mode, dis, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, run_c, stby_c, slp_c, vcode;
  logic [1:0] mode;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0; // Cycle count for the hang guard
  btcr_regs btcr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fuse_ready_i(ready),
    .fuse_run_code_i(run_c), .fuse_stby_code_i(stby_c), .fuse_slp_code_i(slp_c),
    .fuse_run_enable_i(run_en), .fuse_standby_enable_i(stby_en),
    .fuse_discharge_disable_i(dis_dis), .seq_slot_i(slot), .device_mode_i(mode),
    .regulator_on_o(on), .low_power_o(lp), .forced_pwm_o(forced_pulse_width_mode),
    .discharge_connect_o(dis), .voltage_code_o(vcode));
  // Free-running 200 MHz clock
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // About twenty times the expected run, so a stuck handshake cannot hang the bench
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for ready, no fixed latency assumed
  task xfer(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk_i);
    penable <= 1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rchk(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00, 4'h0);
    chk(rd, exp);
  endtask
  // Output pins packed as on, low power, forced, discharge, code
  task ochk(input logic [7:0] exp);
    chk({24'h0, on, lp, forced_pulse_width_mode, dis, vcode}, {24'h0, exp});
  endtask
  task t_reset;
    rchk(`BTCR_IDX_CTRL, 32'h0);
    repeat (6) @(posedge clk_i);
    ochk(8'h10);
    $display("test reset done");
  endtask
  task t_fuse;
    run_c <= 4'hA;
    stby_c <= 4'h5;
    slp_c <= 4'h3;
    run_en <= 1;
    stby_en <= 1;
    dis_dis <= 1;
    ready <= 1;
    repeat (8) @(posedge clk_i);
    rchk(`BTCR_IDX_RUN_VOLT, 32'h0A);
    rchk(`BTCR_IDX_STBY_VOLT, 32'h05);
    rchk(`BTCR_IDX_SLP_VOLT, 32'h03);
    rchk(`BTCR_IDX_CTRL, 32'h82);
    slot <= 1;
    repeat (6) @(posedge clk_i);
    rchk(`BTCR_IDX_CTRL, 32'h83);
    ochk(8'h8A);
    $display("test fuse load done");
  endtask
  task t_ro;
    for (int i = 0; i < 3; i++) xfer(1'b1, 10'(`BTCR_IDX_RUN_VOLT + i), 8'hFF, 4'hF);
    rchk(`BTCR_IDX_RUN_VOLT, 32'h0A);
    rchk(`BTCR_IDX_STBY_VOLT, 32'h05);
    rchk(`BTCR_IDX_SLP_VOLT, 32'h03);
    xfer(1'b1, `BTCR_IDX_CTRL, 8'h30, 4'h0);
    rchk(`BTCR_IDX_CTRL, 32'h83);
    xfer(1'b1, `BTCR_IDX_CTRL, 8'hFF, 4'hF);
    rchk(`BTCR_IDX_CTRL, 32'hCF);
    rchk(10'h042, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test read-only and map done");
  endtask
  // Control value, device mode and expected pins for each row
  task t_modes;
    logic [7:0] cv[7] = '{8'hCF, 8'h0B, 8'h0D, 8'h8D, 8'h89, 8'h00, 8'h07};
    logic [1:0] mv[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
    logic [7:0] ev[7] = '{8'hAA, 8'hC5, 8'h15, 8'hC3, 8'h03, 8'h1A, 8'h13};
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, `BTCR_IDX_CTRL, cv[i], 4'h1);
      mode <= mv[i];
      repeat (6) @(posedge clk_i);
      ochk(ev[i]);
    end
    $display("test modes done");
  endtask
  initial begin
    {rst_i, psel, penable, pwrite, ready, run_en, stby_en, dis_dis, slot} = 9'h100;
    {paddr, pwdata, pstrb, run_c, stby_c, slp_c, mode} = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_fuse;
    t_ro;
    t_modes;
    summarize;
  end
endmodule
